// >>> core/can_message_object_store.sv
// Message object store with acceptance filter and transmit selection
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
//
// Overview of operation
// - Fifteen objects: id word, data, control, config
// - Multiple matches: data to lowest free object, remote to lowest match
// - Data frame stores data, full id, length
// - Remote frame stores only length code
// - Chained receive objects fill ascending order
// - Bit31 media select, bits30/29 global selects
// - Extended frames only to extended objects
// - Data to receive objects, remote to transmit
// - Selected masks applied; unselected compare fully
// - Remote request sets pending and transmit request
// - Overwrite while fresh sets lost flag
// - Fresh flag set on reception or software
// - Irq pending set per enable on success
// - Irq pending resets high, software clears
// - Transmit request on receive object sends remote
// - Lowest pending transmit object goes first
// - Chain ends may be invalidated, chain adjusts
// - Valid change triggers chain re-examination
// - Irq source code equals object plus two
// - Mask one compares bit, zero ignores
// - Config holds length, direction, extended flag
module can_message_object_store
	import can_obj_pkg::*;
#(
	parameter int OBJ_COUNT = NUM_OBJ
) (
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Global and media filters, init state
	input wire logic init_active,
	input wire logic [EXT_ID_W-1:0] gmask_a,
	input wire logic [EXT_ID_W-1:0] gmask_b,
	input wire logic [MEDIA_W-1:0] media_mask,
	input wire logic [MEDIA_W-1:0] media_arb,
	// Received frame from the protocol engine
	input wire logic rx_valid,
	input wire logic rx_ext,
	input wire logic rx_remote,
	input wire logic [EXT_ID_W-1:0] rx_id,
	input wire logic [CFG_DLC_W-1:0] rx_dlc,
	input wire logic [63:0] rx_data,
	output logic rx_taken,
	output logic [IDX_W-1:0] rx_obj_idx,
	// Frame offered to the protocol engine
	output logic tx_valid,
	output logic [IDX_W-1:0] tx_obj_idx,
	output logic [EXT_ID_W-1:0] tx_id,
	output logic tx_ext,
	output logic tx_remote,
	output logic [CFG_DLC_W-1:0] tx_dlc,
	output logic [63:0] tx_data,
	input wire logic tx_done,
	// Per-object pending flags and source code
	output logic [NUM_OBJ-1:0] irq_pending_vec,
	output logic [4:0] irq_source_code
);
	// Object storage, one entry per object
	logic [31:0] arb_ff [OBJ_COUNT]; // Identifier word
	logic [31:0] dlo_ff [OBJ_COUNT]; // Data bytes 3..0
	logic [31:0] dhi_ff [OBJ_COUNT]; // Data bytes 7..4
	logic [7:0] ctrl_ff [OBJ_COUNT]; // Control flags
	logic [7:0] cfg_ff [OBJ_COUNT]; // Length, direction, format
	// Chain links and valid history
	logic [OBJ_COUNT-1:0] chain_ff; // Object continues the chain below it
	logic [OBJ_COUNT-1:0] valid_prev_ff; // Valid flags one cycle ago
	logic [OBJ_COUNT-1:0] chain_link; // Freshly computed links
	logic [OBJ_COUNT-1:0] valid_vec; // Current valid flags
	// Output registers
	logic [31:0] rdata_ff;
	logic rx_taken_ff;
	logic [IDX_W-1:0] rx_obj_ff;
	logic tx_valid_ff;
	logic [IDX_W-1:0] tx_idx_ff;
	logic [EXT_ID_W-1:0] tx_id_ff;
	logic tx_ext_ff;
	logic tx_remote_ff;
	logic [CFG_DLC_W-1:0] tx_dlc_ff;
	logic [63:0] tx_data_ff;
	logic [NUM_OBJ-1:0] irq_vec_ff;
	logic [4:0] irq_code_ff;
	// Per-object match results
	logic [OBJ_COUNT-1:0] hit; // Valid matching object
	logic [OBJ_COUNT-1:0] free; // Matching and not holding fresh data
	logic [OBJ_COUNT-1:0] tx_want; // Ready to transmit
	logic [OBJ_COUNT-1:0] irq_vec; // Pending flags
	// Picker results
	logic hit_found;
	logic [IDX_W-1:0] hit_idx;
	logic free_found;
	logic [IDX_W-1:0] free_idx;
	logic tx_found;
	logic [IDX_W-1:0] tx_pick;
	logic irq_found;
	logic [IDX_W-1:0] irq_idx;
	// Receive decision
	logic [IDX_W-1:0] chain_end; // Last member of the hit's chain
	logic [IDX_W-1:0] rx_tgt; // Object that takes the frame
	logic store_data;
	logic store_remote;
	logic tx_ack; // Completion of the offered object
	// Register decode
	logic [IDX_W-1:0] obj_sel;
	logic [3:0] word_ofs;
	logic mapped;

	// Object select from upper address, word from lower
	assign obj_sel = reg_addr[7:4];
	assign word_ofs = {reg_addr[3:2], 2'b00};
	assign mapped = (obj_sel < IDX_W'(OBJ_COUNT));

	// Per-object acceptance filter, transmit wish and chain link
	generate
		for (genvar g = 0; g < OBJ_COUNT; g++) begin : obj
			logic [EXT_ID_W-1:0] id_mask; // Combined selected masks
			logic [EXT_ID_W-1:0] id_diff; // Masked mismatch bits
			logic id_ok;
			logic media_ok;
			// Start fully compared, each selected mask adds don't-cares
			always_comb begin
				id_mask = {EXT_ID_W{1'b1}};
				if (arb_ff[g][ARB_GSEL_A]) begin
					id_mask = id_mask & gmask_a;
				end
				if (arb_ff[g][ARB_GSEL_B]) begin
					id_mask = id_mask & gmask_b;
				end
			end
			// Mask bit one compares, zero ignores
			assign id_diff = (rx_id ^ arb_ff[g][EXT_ID_W-1:0]) & id_mask;
			// Standard frames compare only the low identifier bits
			assign id_ok = rx_ext ? (id_diff == '0) : (id_diff[STD_ID_W-1:0] == '0);
			// Media compare on the first two data bytes when selected
			assign media_ok = !arb_ff[g][ARB_MEDIA_SEL]
				|| (((rx_data[MEDIA_W-1:0] ^ media_arb) & media_mask) == '0);
			// Valid, format, direction and identifier all agree
			assign hit[g] = ctrl_ff[g][CTL_VALID]
				&& (cfg_ff[g][CFG_EXT] == rx_ext)
				&& (cfg_ff[g][CFG_DIR] == rx_remote)
				&& id_ok && media_ok;
			// Free means the previous frame was consumed
			assign free[g] = hit[g] && !ctrl_ff[g][CTL_FRESH];
			// Update flag only blocks transmit-direction objects
			assign tx_want[g] = ctrl_ff[g][CTL_VALID] && ctrl_ff[g][CTL_TRANSMIT_REQUEST]
				&& !(cfg_ff[g][CFG_DIR] && ctrl_ff[g][CTL_UPD]);
			assign irq_vec[g] = ctrl_ff[g][CTL_IRQ];
			assign valid_vec[g] = ctrl_ff[g][CTL_VALID];
			// Link to the object below when both are identical receivers
			if (g == 0) begin : first
				assign chain_link[g] = 1'b0;
			end else begin : rest
				assign chain_link[g] = ctrl_ff[g][CTL_VALID] && ctrl_ff[g-1][CTL_VALID]
					&& !cfg_ff[g][CFG_DIR] && !cfg_ff[g-1][CFG_DIR]
					&& (arb_ff[g] == arb_ff[g-1])
					&& (cfg_ff[g][CFG_EXT] == cfg_ff[g-1][CFG_EXT]);
			end
		end
	endgenerate

	// Lowest free matching object
	lowest_pick #(.N(OBJ_COUNT), .W(IDX_W)) u_pick_free (
		.req(free),
		.found(free_found),
		.idx(free_idx)
	);

	// Lowest matching object regardless of content
	lowest_pick #(.N(OBJ_COUNT), .W(IDX_W)) u_pick_hit (
		.req(hit),
		.found(hit_found),
		.idx(hit_idx)
	);

	// Lowest object asking to transmit
	lowest_pick #(.N(OBJ_COUNT), .W(IDX_W)) u_pick_tx (
		.req(tx_want),
		.found(tx_found),
		.idx(tx_pick)
	);

	// Lowest object with pending interrupt
	lowest_pick #(.N(OBJ_COUNT), .W(IDX_W)) u_pick_irq (
		.req(irq_vec),
		.found(irq_found),
		.idx(irq_idx)
	);

	// Walk the chain upward from the first hit to its last member
	always_comb begin
		chain_end = hit_idx;
		for (int i = 1; i < OBJ_COUNT; i++) begin
			if ((IDX_W'(i) == chain_end + 4'h1) && chain_ff[i]) begin
				chain_end = IDX_W'(i);
			end
		end
	end

	// Full chain overwrites its last member, a lone object itself
	assign rx_tgt = (rx_remote || free_found) ? (rx_remote ? hit_idx : free_idx)
		: chain_end;
	// No storage while initialisation holds the bus off
	assign store_data = rx_valid && !init_active && !rx_remote && hit_found;
	assign store_remote = rx_valid && !init_active && rx_remote && hit_found;
	// Completion counts only for an offered object
	assign tx_ack = tx_done && tx_valid_ff;

	// Chain links rebuilt one cycle after any valid flag moves
	always_ff @(posedge mclk) begin
		if (rst) begin
			valid_prev_ff <= '0;
			chain_ff <= '0;
		end else begin
			valid_prev_ff <= valid_vec;
			if (valid_prev_ff != valid_vec) begin
				chain_ff <= chain_link;
			end
		end
	end

	// Identifier word: software writes, data frames replace the id
	always_ff @(posedge mclk) begin
		for (int i = 0; i < OBJ_COUNT; i++) begin
			if (rst) begin
				arb_ff[i] <= ARB_RST;
			end else begin
				// Software write
				if (reg_wr && mapped && obj_sel == IDX_W'(i) && word_ofs == OFS_ARB) begin
					arb_ff[i] <= reg_wdata;
				end
				// Received data frame wins; remote frames leave it alone
				if (store_data && rx_tgt == IDX_W'(i)) begin
					arb_ff[i][EXT_ID_W-1:0] <= rx_ext ? rx_id
						: {{(EXT_ID_W - STD_ID_W){1'b0}}, rx_id[STD_ID_W-1:0]};
				end
			end
		end
	end

	// Data words: software writes, data frames replace all eight bytes
	always_ff @(posedge mclk) begin
		for (int i = 0; i < OBJ_COUNT; i++) begin
			if (rst) begin
				dlo_ff[i] <= DATA_RST;
				dhi_ff[i] <= DATA_RST;
			end else begin
				// Software writes per word
				if (reg_wr && mapped && obj_sel == IDX_W'(i) && word_ofs == OFS_DLO) begin
					dlo_ff[i] <= reg_wdata;
				end
				if (reg_wr && mapped && obj_sel == IDX_W'(i) && word_ofs == OFS_DHI) begin
					dhi_ff[i] <= reg_wdata;
				end
				// Received bytes, byte 0 lowest
				if (store_data && rx_tgt == IDX_W'(i)) begin
					dlo_ff[i] <= rx_data[31:0];
					dhi_ff[i] <= rx_data[63:32];
				end
			end
		end
	end

	// Config byte: length code also updated by any stored frame
	always_ff @(posedge mclk) begin
		for (int i = 0; i < OBJ_COUNT; i++) begin
			if (rst) begin
				cfg_ff[i] <= CFG_RST;
			end else begin
				// Software write, low two bits read zero
				if (reg_wr && mapped && obj_sel == IDX_W'(i) && word_ofs == OFS_CTRL) begin
					cfg_ff[i] <= reg_wdata[15:8] & CFG_WR_MASK;
				end
				// Data and remote frames both carry a length code
				if ((store_data || store_remote) && rx_tgt == IDX_W'(i)) begin
					cfg_ff[i][CFG_DLC_LSB +: CFG_DLC_W] <= rx_dlc;
				end
			end
		end
	end

	// Control flags: software write first, hardware events on top
	always_ff @(posedge mclk) begin
		for (int i = 0; i < OBJ_COUNT; i++) begin
			if (rst) begin
				ctrl_ff[i] <= CTRL_RST;
			end else begin
				// Software write, including clearing irq pending
				if (reg_wr && mapped && obj_sel == IDX_W'(i) && word_ofs == OFS_CTRL) begin
					ctrl_ff[i] <= reg_wdata[7:0];
				end
				// Data stored: fresh set, lost if still unread
				if (store_data && rx_tgt == IDX_W'(i)) begin
					ctrl_ff[i][CTL_FRESH] <= 1'b1;
					if (ctrl_ff[i][CTL_FRESH]) begin
						ctrl_ff[i][CTL_LOST] <= 1'b1;
					end
					if (ctrl_ff[i][CTL_RECEIVE_IRQ_ENABLE]) begin
						ctrl_ff[i][CTL_IRQ] <= 1'b1;
					end
				end
				// Remote request arms an answer
				if (store_remote && rx_tgt == IDX_W'(i)) begin
					ctrl_ff[i][CTL_RMT] <= 1'b1;
					ctrl_ff[i][CTL_TRANSMIT_REQUEST] <= 1'b1;
				end
				// Successful send clears request and pending remote
				if (tx_ack && tx_idx_ff == IDX_W'(i)) begin
					ctrl_ff[i][CTL_RMT] <= 1'b0;
					ctrl_ff[i][CTL_TRANSMIT_REQUEST] <= 1'b0;
					if (ctrl_ff[i][CTL_TRANSMIT_IRQ_ENABLE]) begin
						ctrl_ff[i][CTL_IRQ] <= 1'b1;
					end
				end
			end
		end
	end

	// Register read, data valid only in the following cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_ff <= '0;
		end else if (reg_rd && mapped) begin
			unique case (word_ofs)
				OFS_ARB: rdata_ff <= arb_ff[obj_sel];
				OFS_DLO: rdata_ff <= dlo_ff[obj_sel];
				OFS_DHI: rdata_ff <= dhi_ff[obj_sel];
				OFS_CTRL: rdata_ff <= {16'h0000, cfg_ff[obj_sel], ctrl_ff[obj_sel]};
				default: rdata_ff <= '0;
			endcase
		end else begin
			// Unmapped or idle reads return zero
			rdata_ff <= '0;
		end
	end

	// Reception report to the protocol engine
	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_taken_ff <= 1'b0;
			rx_obj_ff <= '0;
		end else begin
			rx_taken_ff <= store_data || store_remote;
			if (store_data || store_remote) begin
				rx_obj_ff <= rx_tgt;
			end
		end
	end

	// Offer the lowest requesting object; drop for a cycle after done
	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_valid_ff <= 1'b0;
			tx_idx_ff <= '0;
			tx_id_ff <= '0;
			tx_ext_ff <= 1'b0;
			tx_remote_ff <= 1'b0;
			tx_dlc_ff <= '0;
			tx_data_ff <= '0;
		end else begin
			tx_valid_ff <= tx_found && !init_active && !tx_ack;
			if (tx_found) begin
				tx_idx_ff <= tx_pick;
				tx_id_ff <= arb_ff[tx_pick][EXT_ID_W-1:0];
				tx_ext_ff <= cfg_ff[tx_pick][CFG_EXT];
				// Receive-direction object asks with a remote frame
				tx_remote_ff <= !cfg_ff[tx_pick][CFG_DIR];
				tx_dlc_ff <= cfg_ff[tx_pick][CFG_DLC_LSB +: CFG_DLC_W];
				tx_data_ff <= {dhi_ff[tx_pick], dlo_ff[tx_pick]};
			end
		end
	end

	// Pending flags and source code, lowest object wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_vec_ff <= '0;
			irq_code_ff <= IRQ_CODE_IDLE;
		end else begin
			irq_vec_ff <= NUM_OBJ'(irq_vec);
			irq_code_ff <= irq_found ? (IRQ_CODE_BASE + 5'(irq_idx)) : IRQ_CODE_IDLE;
		end
	end

	// Outputs straight from registers
	assign reg_rdata = rdata_ff;
	assign rx_taken = rx_taken_ff;
	assign rx_obj_idx = rx_obj_ff;
	assign tx_valid = tx_valid_ff;
	assign tx_obj_idx = tx_idx_ff;
	assign tx_id = tx_id_ff;
	assign tx_ext = tx_ext_ff;
	assign tx_remote = tx_remote_ff;
	assign tx_dlc = tx_dlc_ff;
	assign tx_data = tx_data_ff;
	assign irq_pending_vec = irq_vec_ff;
	assign irq_source_code = irq_code_ff;
endmodule : can_message_object_store

// >>> core/can_obj_pkg.sv
// Shared constants for the CAN message object store
package can_obj_pkg;
	// Object count and index width
	localparam int NUM_OBJ = 15;
	localparam int IDX_W = 4;
	localparam int ADDR_W = 8;
	// Identifier widths
	localparam int EXT_ID_W = 29;
	localparam int STD_ID_W = 11;
	localparam int MEDIA_W = 16;
	// Byte offsets of the words inside one object (16-byte stride)
	localparam logic [3:0] OFS_ARB = 4'h0;
	localparam logic [3:0] OFS_DLO = 4'h4;
	localparam logic [3:0] OFS_DHI = 4'h8;
	localparam logic [3:0] OFS_CTRL = 4'hC;
	// Arbitration word fields
	localparam int ARB_MEDIA_SEL = 31;
	localparam int ARB_GSEL_A = 30;
	localparam int ARB_GSEL_B = 29;
	// Control byte fields
	localparam int CTL_RMT = 7;
	localparam int CTL_TRANSMIT_REQUEST = 6;
	localparam int CTL_LOST = 5;
	localparam int CTL_UPD = 5;
	localparam int CTL_FRESH = 4;
	localparam int CTL_VALID = 3;
	localparam int CTL_RECEIVE_IRQ_ENABLE = 2;
	localparam int CTL_TRANSMIT_IRQ_ENABLE = 1;
	localparam int CTL_IRQ = 0;
	// Configuration byte fields
	localparam int CFG_DLC_LSB = 4;
	localparam int CFG_DLC_W = 4;
	localparam int CFG_DIR = 3;
	localparam int CFG_EXT = 2;
	localparam logic [7:0] CFG_WR_MASK = 8'hFC;
	// Reset values
	localparam logic [31:0] ARB_RST = 32'h0000_0000;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [7:0] CTRL_RST = 8'h01;
	localparam logic [7:0] CFG_RST = 8'h00;
	// Interrupt source codes
	localparam logic [4:0] IRQ_CODE_IDLE = 5'h00;
	localparam logic [4:0] IRQ_CODE_BASE = 5'h02;
endpackage : can_obj_pkg

// >>> core/lowest_pick.sv
// Priority picker: finds the lowest set bit of a request vector
`timescale 1ns/100ps
module lowest_pick #(
	parameter int N = 15,
	parameter int W = 4
) (
	input wire logic [N-1:0] req,
	output logic found,
	output logic [W-1:0] idx
);
	// Scan downward so the lowest set index is the last one kept
	always_comb begin
		found = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				idx = W'(i);
			end
		end
	end
endmodule : lowest_pick

// >>> testbench/can_obj_chk_assertions.sv
// Port-level checks for the message object store
`timescale 1ns/100ps
module can_obj_chk
	import can_obj_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic init_active,
	input wire logic rx_valid,
	input wire logic rx_taken,
	input wire logic [IDX_W-1:0] rx_obj_idx,
	input wire logic tx_valid,
	input wire logic [IDX_W-1:0] tx_obj_idx,
	input wire logic tx_done,
	input wire logic [NUM_OBJ-1:0] irq_pending_vec,
	input wire logic [4:0] irq_source_code
);
	default clocking dclk @(posedge mclk); endclocking
	default disable iff (rst);
	logic [3:0] wofs; // Word offset of the bus address
	assign wofs = {reg_addr[3:2], 2'b00};
	// Source code expected for a pending vector
	function automatic logic [4:0] code_of(logic [NUM_OBJ-1:0] v);
		code_of = IRQ_CODE_IDLE;
		for (int i = NUM_OBJ - 1; i >= 0; i--) begin
			if (v[i]) begin
				code_of = IRQ_CODE_BASE + 5'(i);
			end
		end
	endfunction : code_of
	AST_RDATA_IDLE: assert property (
		!reg_rd |=> reg_rdata == 32'h0) else $error("read data without a read");
	AST_RX_CAUSE: assert property (
		!(rx_valid && !init_active) |=> !rx_taken) else $error("store without a frame");
	AST_IDX_RANGE: assert property (
		(rx_taken |-> rx_obj_idx <= 4'hE) and (tx_valid |-> tx_obj_idx <= 4'hE))
		else $error("object index out of range");
	AST_TX_GAP: assert property (
		tx_valid && tx_done |=> !tx_valid) else $error("offer stands after done");
	AST_IRQ_CODE: assert property (
		irq_source_code == code_of(irq_pending_vec)) else $error("wrong source code");
	AST_IDX_HOLD: assert property (
		!rx_taken |-> $stable(rx_obj_idx)) else $error("stored index moved");
	AST_IRQ_STICKY: assert property (
		|($past(irq_pending_vec) & ~irq_pending_vec) |-> $past(reg_wr, 2)
		&& $past(wofs, 2) == OFS_CTRL) else $error("pending dropped by itself");
	AST_IRQ_CAUSE: assert property (
		|(irq_pending_vec & ~$past(irq_pending_vec)) |-> $past(rx_taken)
		|| $past(tx_done, 2) || $past(reg_wr, 2)
		|| $past(rst, 2)) else $error("pending without event");
	// Main scenarios reached
	cover property (rx_taken && rx_obj_idx == 4'h2);
	cover property (tx_valid && tx_done);
	cover property (irq_source_code == 4'h3);
endmodule : can_obj_chk

// >>> testbench/can_bus_partner.sv
// Far-side model: frame source and transmit acknowledger
`timescale 1ns/100ps
module can_bus_partner
	import can_obj_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] ack_delay,
	input wire logic tx_valid,
	output logic tx_done,
	output logic rx_valid,
	output logic rx_ext,
	output logic rx_remote,
	output logic [EXT_ID_W-1:0] rx_id,
	output logic [CFG_DLC_W-1:0] rx_dlc,
	output logic [63:0] rx_data
);
	logic [3:0] wait_cnt; // Cycles the offer has stood
	// Idle lines before the first frame
	initial begin
		rx_valid = 1'b0;
		{rx_ext, rx_remote, rx_id, rx_dlc, rx_data} = '1;
	end
	// Acknowledge an offer after ack_delay cycles
	always @(posedge mclk) begin
		// Each line assigned once per edge
		if (!rst && tx_valid && !tx_done && wait_cnt == ack_delay) begin
			tx_done <= 1'b1;
		end else begin
			tx_done <= 1'b0;
		end
		if (!rst && tx_valid && !tx_done && wait_cnt != ack_delay) begin
			wait_cnt <= wait_cnt + 4'h1;
		end else begin
			wait_cnt <= 4'h0;
		end
	end
	// One frame for one cycle; released lines then show garbage
	task automatic send(input logic ext, input logic rmt, input logic [28:0] id,
		input logic [3:0] payload_length_code, input logic [63:0] data);
		@(posedge mclk);
		{rx_valid, rx_ext, rx_remote} <= {1'b1, ext, rmt};
		{rx_id, rx_dlc, rx_data} <= {id, payload_length_code, data};
		@(posedge mclk);
		rx_valid <= 1'b0;
		{rx_id, rx_dlc, rx_data} <= ~{id, payload_length_code, data};
	endtask : send
endmodule : can_bus_partner

// >>> testbench/tb.sv
// Top bench for the message object store
`timescale 1ns/100ps
module tb
	import can_obj_pkg::*;
;
	logic mclk, rst, reg_wr, reg_rd, init_active;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [28:0] gmask_a, gmask_b, rx_id, tx_id;
	logic [15:0] media_mask, media_arb;
	logic rx_valid, rx_ext, rx_remote, rx_taken, tx_valid, tx_ext, tx_remote, tx_done;
	logic [3:0] ack_delay, rx_dlc, tx_dlc, rx_obj_idx, tx_obj_idx;
	logic [4:0] irq_source_code;
	logic [63:0] rx_data, tx_data;
	logic [14:0] irq_pending_vec;
	int errors, n_checks, cyc, seen;
	// Register round trips: address, write, readback
	typedef struct {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
	} row_s;
	row_s rows [4] = '{'{8'h00, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
		'{8'hE4, 32'hA5A5_5A5A, 32'hA5A5_5A5A}, '{8'h2C, 32'hFFFF_FFF7, 32'h0000_FCF7},
		'{8'hF4, 32'hFFFF_FFFF, 32'h0000_0000}};
	can_message_object_store i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.init_active(init_active), .gmask_a(gmask_a), .gmask_b(gmask_b),
		.media_mask(media_mask), .media_arb(media_arb), .rx_valid(rx_valid), .rx_ext(rx_ext),
		.rx_remote(rx_remote), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
		.rx_taken(rx_taken), .rx_obj_idx(rx_obj_idx), .tx_valid(tx_valid),
		.tx_obj_idx(tx_obj_idx), .tx_id(tx_id), .tx_ext(tx_ext), .tx_remote(tx_remote),
		.tx_dlc(tx_dlc), .tx_data(tx_data), .tx_done(tx_done),
		.irq_pending_vec(irq_pending_vec), .irq_source_code(irq_source_code));
	can_bus_partner i_bus (.mclk(mclk), .rst(rst), .ack_delay(ack_delay),
		.tx_valid(tx_valid), .tx_done(tx_done), .rx_valid(rx_valid), .rx_ext(rx_ext),
		.rx_remote(rx_remote), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data));
	// Compare and count
	task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
		n_checks++;
		if (seen_v !== exp_v) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen_v, exp_v);
		end
	endtask : chk
	// Register bus cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rd
	task automatic cfg_obj(input logic [3:0] n, input logic [31:0] arb, input logic [15:0] c);
		wr({n, OFS_ARB}, arb);
		wr({n, OFS_CTRL}, {16'h0, c});
	endtask : cfg_obj
	// Frame in, then whether and where it landed
	task automatic rx(input logic ext, input logic rmt, input logic [28:0] id,
		input logic [3:0] payload_length_code, input logic [3:0] idx, input logic take);
		i_bus.send(ext, rmt, id, payload_length_code, 64'h8877_6655_4433_2211);
		#1;
		chk(rx_taken, take);
		if (take) chk(rx_obj_idx, idx);
	endtask : rx
	// Wait for one offer, check it, wait until it is gone
	task automatic wait_tx(input logic [3:0] idx, input logic rmt, input logic [28:0] id,
		input logic [3:0] payload_length_code, input logic ext, input logic [63:0] data);
		int n;
		n = 0;
		while (tx_valid !== 1'b1 && n < 50) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(tx_obj_idx, idx);
		chk(tx_remote, rmt);
		chk(tx_id, id);
		chk(tx_dlc, payload_length_code);
		chk(tx_ext, ext);
		chk(tx_data[31:0], data[31:0]);
		chk(tx_data[63:32], data[63:32]);
		while (tx_valid === 1'b1 && n < 100) begin
			@(posedge mclk);
			#1;
			n++;
		end
	endtask : wait_tx
	task automatic close_out();
		$display("Checks %0d, errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	// Clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			close_out();
		end
	end
	// Main sequence
	initial begin
		{rst, reg_wr, reg_rd, init_active, reg_addr, reg_wdata} = {1'b1, 43'h0};
		{gmask_a, ack_delay} = {29'h1FFF_FF00, 4'h5};
		{gmask_b, media_mask, media_arb} = {29'h1FFF_FFF0, 16'hFF00, 16'h3300};
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		chk(irq_pending_vec, 15'h7FFF);
		chk(irq_source_code, 4'h2);
		rd(8'hEC, 32'h0000_0001);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rows[i].rdata);
		end
		for (int i = 0; i < 15; i++) wr(8'(i * 16 + 12), 32'h0);
		cfg_obj(4'h1, 32'h0000_0123, 16'h000C);
		cfg_obj(4'h2, 32'h0000_0123, 16'h000C);
		cfg_obj(4'h3, 32'h4ABC_DEF0, 16'h040C);
		cfg_obj(4'h4, 32'h0000_0055, 16'h082A);
		cfg_obj(4'h5, 32'h0000_0055, 16'h0840);
		#1;
		chk(irq_source_code, 4'h0);
		rx(1'b1, 1'b0, 29'h123, 4'h8, 4'h0, 1'b0);
		rx(1'b0, 1'b0, 29'h123, 4'h8, 4'h1, 1'b1);
		@(posedge mclk);
		#1;
		chk(irq_source_code, 4'h3);
		rd(8'h14, 32'h4433_2211);
		rd(8'h1C, 32'h0000_801D);
		rx(1'b0, 1'b0, 29'h123, 4'h8, 4'h2, 1'b1);
		rx(1'b0, 1'b0, 29'h123, 4'h8, 4'h2, 1'b1);
		rd(8'h2C, 32'h0000_803D);
		rx(1'b1, 1'b0, 29'h0ABC_DE12, 4'h8, 4'h3, 1'b1);
		rd(8'h30, 32'h4ABC_DE12);
		// Media filter and second global mask on one object
		cfg_obj(4'h6, 32'hA000_0070, 16'h0008);
		rx(1'b0, 1'b0, 29'h07A, 4'h8, 4'h6, 1'b0);
		@(posedge mclk);
		media_arb <= 16'h2200;
		rx(1'b0, 1'b0, 29'h07A, 4'h8, 4'h6, 1'b1);
		rd(8'h60, 32'hA000_007A);
		rx(1'b0, 1'b1, 29'h055, 4'h2, 4'h4, 1'b1);
		rd(8'h4C, 32'h0000_28EA);
		rd(8'h40, 32'h0000_0055);
		rd(8'h44, 32'h0000_0000);
		seen = 0;
		repeat (8) begin
			@(posedge mclk);
			#1;
			if (tx_valid === 1'b1) seen++;
		end
		chk(seen, 0);
		@(posedge mclk);
		init_active <= 1'b1;
		wr(8'h4C, 32'h0000_28CA);
		wr(8'h1C, 32'h0000_8048);
		@(posedge mclk);
		init_active <= 1'b0;
		wait_tx(4'h1, 1'b1, 29'h123, 4'h8, 1'b0, 64'h8877_6655_4433_2211);
		@(posedge mclk);
		ack_delay <= 4'h0;
		wait_tx(4'h4, 1'b0, 29'h055, 4'h2, 1'b0, 64'h0);
		rd(8'h4C, 32'h0000_280B);
		rd(8'h1C, 32'h0000_8008);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rd(8'h4C, 32'h0000_0001);
		close_out();
	end
endmodule : tb
bind can_message_object_store can_obj_chk i_chk (.mclk(mclk), .rst(rst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.init_active(init_active), .rx_valid(rx_valid), .rx_taken(rx_taken),
	.rx_obj_idx(rx_obj_idx), .tx_valid(tx_valid), .tx_obj_idx(tx_obj_idx),
	.tx_done(tx_done), .irq_pending_vec(irq_pending_vec),
	.irq_source_code(irq_source_code));
